// [hdl/baud_pkg.sv]
// constants and types shared by the serial baud rate generator
`default_nettype none

package baud_pkg;

   // -----------------------------------------------------------------
   // bus geometry
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned DIV_W  = 16;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [11:0] OFS_BAUD_CTL = 12'h000;
   localparam logic [11:0] OFS_RX_CTL   = 12'h004;
   localparam logic [11:0] OFS_DIV_LO   = 12'h008;
   localparam logic [11:0] OFS_DIV_HI   = 12'h00c;
   localparam logic [11:0] OFS_TX_CTL   = 12'h010;

   // -----------------------------------------------------------------
   // baud_control field positions
   // -----------------------------------------------------------------
   localparam int unsigned BC_OVF   = 7;
   localparam int unsigned BC_IDLE  = 6;
   localparam int unsigned BC_POL   = 4;
   localparam int unsigned BC_WIDE  = 3;
   localparam int unsigned BC_WAKE  = 1;
   localparam int unsigned BC_AUTOBAUD_ENABLE = 0;

   // -----------------------------------------------------------------
   // transmit_status_control field positions
   // -----------------------------------------------------------------
   localparam int unsigned TX_SYNC  = 4;
   localparam int unsigned TX_HIGH  = 2;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_CNT  = 16'h0000;

   // -----------------------------------------------------------------
   // prescale left to the shift logic after each tick
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PRE_DIV64,
      PRE_DIV16,
      PRE_DIV4
   } prescale_t;

endpackage

`default_nettype wire

// [hdl/serial_baud_rate_generator.sv]
// rate divider for the enhanced serial port with its apb register file
// Summary of operation
// - async, narrow, low speed: bit rate is clock over 64(n+1).
// - async, wide, low speed: bit rate is clock over 16(n+1).
// - sync, narrow divisor: bit clock is clock over 4(n+1).
// - wide mode: divisor n is the high byte joined to the low byte; narrow mode: low byte only.
// - divisor is 16 bits, low byte bits 7:0, high byte 15:8.
// - baud control: overflow 7, idle 6, polarity 4, wide 3, wake 1, autobaud 0.
// - transmit control: sync select bit 4, high speed bit 2.
// - in sync mode the high speed select is ignored.
// - baud control bits 5 and 2 read as zero.
// - reset leaves narrow divisor; wide select switches to 16 bits.
// - writing either divisor byte clears the running divider.
// - async, narrow, high speed: clock over 16(n+1).
`default_nettype none

module serial_baud_rate_generator (
   // clock and reset
   input  wire logic                i_mclk,
   input  wire logic                i_rstn,
   // apb slave
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [11:0]         i_paddr,
   input  wire logic [31:0]         i_pwdata,
   output logic [31:0]              o_prdata,
   output logic                     o_pready,
   output logic                     o_pslverr,
   // status from the shift logic
   input  wire logic                i_receive_idle,
   input  wire logic                i_autobaud_overflow,
   // to the shift logic
   output logic                     o_rate_tick,
   output baud_pkg::prescale_t      o_prescale,
   output logic                     o_clock_polarity_select,
   output logic                     o_wakeup_enable,
   output logic                     o_autobaud_enable,
   output logic [7:0]               o_receive_status_control,
   output logic [7:0]               o_transmit_status_control
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        ovf;
      logic        pol;
      logic        wide;
      logic        wake;
      logic        autobaud_enable;
      logic [7:0]  rx_ctl;
      logic [7:0]  div_lo;
      logic [7:0]  div_hi;
      logic [7:0]  tx_ctl;
      logic [15:0] count;
      logic        tick;
      logic [7:0]  rdata;
   } state_t;

   state_t      s_reg;
   state_t      s_next;

   logic        setup;
   logic        access;
   logic        wr_en;
   logic        div_wr;
   logic        mapped;
   logic        sync_mode;
   logic        high_speed;
   logic [15:0] eff_div;
   logic [7:0]  rd_mux;

   // -----------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------
   assign setup  = i_psel && !i_penable;
   assign access = i_psel && i_penable;

   always_comb begin
      case (i_paddr)
         baud_pkg::OFS_BAUD_CTL,
         baud_pkg::OFS_RX_CTL,
         baud_pkg::OFS_DIV_LO,
         baud_pkg::OFS_DIV_HI,
         baud_pkg::OFS_TX_CTL: mapped = 1'b1;
         default:              mapped = 1'b0;
      endcase
   end

   assign wr_en  = access && i_pwrite && mapped;
   assign div_wr = wr_en && (i_paddr == baud_pkg::OFS_DIV_LO ||
                             i_paddr == baud_pkg::OFS_DIV_HI);

   // zero wait states; unmapped access answers with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = access && !mapped;
   assign o_prdata  = {24'h000000, s_reg.rdata};

   // -----------------------------------------------------------------
   // rate selection
   // -----------------------------------------------------------------
   assign sync_mode  = s_reg.tx_ctl[baud_pkg::TX_SYNC];
   assign high_speed = s_reg.tx_ctl[baud_pkg::TX_HIGH];

   // narrow mode ignores the high byte
   assign eff_div = s_reg.wide ? {s_reg.div_hi, s_reg.div_lo}
                               : {8'h00, s_reg.div_lo};

   always_comb begin
      if (sync_mode) begin
         o_prescale = baud_pkg::PRE_DIV4;
      end else if (s_reg.wide) begin
         o_prescale = high_speed ? baud_pkg::PRE_DIV4
                                 : baud_pkg::PRE_DIV16;
      end else begin
         o_prescale = high_speed ? baud_pkg::PRE_DIV16
                                 : baud_pkg::PRE_DIV64;
      end
   end

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always_comb begin
      case (i_paddr)
         baud_pkg::OFS_BAUD_CTL: rd_mux = {s_reg.ovf,
                                           i_receive_idle,
                                           1'b0,
                                           s_reg.pol,
                                           s_reg.wide,
                                           1'b0,
                                           s_reg.wake,
                                           s_reg.autobaud_enable};
         baud_pkg::OFS_RX_CTL:   rd_mux = s_reg.rx_ctl;
         baud_pkg::OFS_DIV_LO:   rd_mux = s_reg.div_lo;
         baud_pkg::OFS_DIV_HI:   rd_mux = s_reg.div_hi;
         baud_pkg::OFS_TX_CTL:   rd_mux = s_reg.tx_ctl;
         default:                rd_mux = 8'h00;
      endcase
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      s_next      = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.count == baud_pkg::RST_CNT) begin
         s_next.count = eff_div;
         s_next.tick  = 1'b1;
      end else begin
         s_next.count = s_reg.count - 16'h0001;
      end
      if (wr_en) begin
         case (i_paddr)
            baud_pkg::OFS_BAUD_CTL: begin
               s_next.ovf   = i_pwdata[baud_pkg::BC_OVF];
               s_next.pol   = i_pwdata[baud_pkg::BC_POL];
               s_next.wide  = i_pwdata[baud_pkg::BC_WIDE];
               s_next.wake  = i_pwdata[baud_pkg::BC_WAKE];
               s_next.autobaud_enable = i_pwdata[baud_pkg::BC_AUTOBAUD_ENABLE];
            end
            baud_pkg::OFS_RX_CTL: s_next.rx_ctl = i_pwdata[7:0];
            baud_pkg::OFS_DIV_LO: s_next.div_lo = i_pwdata[7:0];
            baud_pkg::OFS_DIV_HI: s_next.div_hi = i_pwdata[7:0];
            baud_pkg::OFS_TX_CTL: s_next.tx_ctl = i_pwdata[7:0];
            default: s_next.rx_ctl = s_reg.rx_ctl;
         endcase
      end
      // restart at once so the new rate needs no old period to expire
      if (div_wr) begin
         s_next.count = baud_pkg::RST_CNT;
         s_next.tick  = 1'b0;
      end
      // a new overflow beats a software clear in the same cycle
      if (i_autobaud_overflow) begin
         s_next.ovf = 1'b1;
      end
      if (setup && !i_pwrite) begin
         s_next.rdata = rd_mux;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rate_tick               = s_reg.tick;
   assign o_clock_polarity_select   = s_reg.pol;
   assign o_wakeup_enable           = s_reg.wake;
   assign o_autobaud_enable         = s_reg.autobaud_enable;
   assign o_receive_status_control  = s_reg.rx_ctl;
   assign o_transmit_status_control = s_reg.tx_ctl;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   AST_PRE64: assert property (
      (!sync_mode && !s_reg.wide && !high_speed)
         |-> o_prescale == baud_pkg::PRE_DIV64)
      else $error("low speed narrow async not div 64");

   AST_PRE16W: assert property (
      (!sync_mode && s_reg.wide && !high_speed)
         |-> o_prescale == baud_pkg::PRE_DIV16)
      else $error("low speed wide async not div 16");

   AST_SYNC4: assert property (
      sync_mode |-> o_prescale == baud_pkg::PRE_DIV4)
      else $error("sync mode not div 4");

   AST_WIDEN: assert property (
      s_reg.wide |-> eff_div == {s_reg.div_hi, s_reg.div_lo})
      else $error("wide divisor not byte pair");

   AST_NARROW: assert property (
      !s_reg.wide |-> eff_div[15:8] == 8'h00)
      else $error("narrow divisor uses high byte");

   AST_TXPOS: assert property (
      (wr_en && i_paddr == baud_pkg::OFS_TX_CTL)
         |=> sync_mode == $past(i_pwdata[baud_pkg::TX_SYNC])
             && high_speed == $past(i_pwdata[baud_pkg::TX_HIGH]))
      else $error("sync or high speed bit misplaced");

   AST_SYNCHS: assert property (
      (sync_mode && $changed(high_speed) && $stable(sync_mode))
         |-> o_prescale == baud_pkg::PRE_DIV4)
      else $error("high speed select moved sync rate");

   AST_RSV: assert property (
      (setup && !i_pwrite && i_paddr == baud_pkg::OFS_BAUD_CTL)
         |=> o_prdata[5] == 1'b0 && o_prdata[2] == 1'b0)
      else $error("reserved baud control bit reads one");

   AST_WIDEPOS: assert property (
      (wr_en && i_paddr == baud_pkg::OFS_BAUD_CTL)
         |=> s_reg.wide == $past(i_pwdata[baud_pkg::BC_WIDE]))
      else $error("wide select not at bit 3");

   AST_HS16: assert property (
      (!sync_mode && !s_reg.wide && high_speed)
         |-> o_prescale == baud_pkg::PRE_DIV16)
      else $error("high speed narrow async not div 16");

   AST_HS4W: assert property (
      (!sync_mode && s_reg.wide && high_speed)
         |-> o_prescale == baud_pkg::PRE_DIV4)
      else $error("high speed wide async not div 4");

   AST_CLEAR: assert property (
      div_wr |=> s_reg.count == 16'h0000 ##1 o_rate_tick)
      else $error("divisor write did not restart divider");

   AST_RELOAD: assert property (
      (s_reg.count == 16'h0000 && !div_wr)
         |=> o_rate_tick && s_reg.count == $past(eff_div))
      else $error("divider did not reload with tick");

   AST_LOBYTE: assert property (
      (wr_en && i_paddr == baud_pkg::OFS_DIV_LO)
         |=> s_reg.div_lo == $past(i_pwdata[7:0]))
      else $error("low divisor byte not stored");

   AST_HIBYTE: assert property (
      (wr_en && i_paddr == baud_pkg::OFS_DIV_HI)
         |=> s_reg.div_hi == $past(i_pwdata[7:0]))
      else $error("high divisor byte not stored");

   AST_OVFSET: assert property (
      i_autobaud_overflow |=> s_reg.ovf)
      else $error("overflow input did not set flag");

   AST_IDLE: assert property (
      (setup && !i_pwrite && i_paddr == baud_pkg::OFS_BAUD_CTL)
         |=> o_prdata[baud_pkg::BC_IDLE] == $past(i_receive_idle))
      else $error("receive idle not shown at bit 6");

   AST_TICK1: assert property (
      (o_rate_tick && s_reg.count != 16'h0000)
         |=> !o_rate_tick)
      else $error("tick longer than one cycle");

   COV_TICK: cover property (o_rate_tick ##[1:8] o_rate_tick);
   COV_DIVWR: cover property (div_wr ##2 o_rate_tick);
   COV_ERR: cover property (o_pslverr);
   COV_WIDE: cover property (s_reg.wide && o_rate_tick);
   COV_SYNC: cover property (sync_mode && o_rate_tick);

endmodule // serial_baud_rate_generator

`default_nettype wire

// [test/shift_logic_model.sv]
// behavioural model of the serial shift logic beside the rate divider
`default_nettype none

module shift_logic_model (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // from the rate divider
   input  wire logic        i_rate_tick,
   // scenario controls
   input  wire logic        i_idle_level,
   input  wire logic        i_overflow_pulse,
   // to the divider and the bench
   output logic             o_receive_idle,
   output logic             o_autobaud_overflow,
   output logic [15:0]      o_period
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] gap;

   assign o_receive_idle      = i_idle_level;
   assign o_autobaud_overflow = i_overflow_pulse;

   // cycles between the last two ticks
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         gap      <= 16'h0001;
         o_period <= 16'h0000;
      end else if (i_rate_tick) begin
         o_period <= gap;
         gap      <= 16'h0001;
      end else begin
         gap <= gap + 16'h0001;
      end
   end
endmodule // shift_logic_model

`default_nettype wire

// [test/serial_baud_rate_generator_bench.sv]
// self-checking bench for the serial baud rate generator
`default_nettype none

module serial_baud_rate_generator_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                mclk = 1'b0;
   logic                rstn = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h00000000;
   logic                idle_lvl = 1'b0;
   logic                ovf_pulse = 1'b0;
   logic [31:0]         prdata, rd;
   logic                pready, pslverr, err, tick, idle, ovf;
   logic                pol, wake, autobaud_enable;
   logic [7:0]          rx_byte, tx_byte;
   logic [15:0]         period;
   baud_pkg::prescale_t prescale;
   logic [11:0]         ofs [5];
   int                  error_cnt = 0;
   int                  total_checks = 0;

   always #5 mclk = ~mclk;

   serial_baud_rate_generator i_dut (
      .i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_receive_idle(idle), .i_autobaud_overflow(ovf),
      .o_rate_tick(tick), .o_prescale(prescale),
      .o_clock_polarity_select(pol), .o_wakeup_enable(wake),
      .o_autobaud_enable(autobaud_enable), .o_receive_status_control(rx_byte),
      .o_transmit_status_control(tx_byte));

   shift_logic_model i_far (
      .i_mclk(mclk), .i_rstn(rstn), .i_rate_tick(tick),
      .i_idle_level(idle_lvl), .i_overflow_pulse(ovf_pulse),
      .o_receive_idle(idle), .o_autobaud_overflow(ovf), .o_period(period));

   task automatic chk(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer: setup, then access held until pready
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(nm, rd, {24'h000000, e});
      chk("pslverr", {31'h0, err}, 32'h0);
   endtask

   task automatic pchk(input string nm, input baud_pkg::prescale_t e);
      chk(nm, {30'h0, prescale}, {30'h0, e});
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end

   initial begin
      ofs = '{baud_pkg::OFS_BAUD_CTL, baud_pkg::OFS_RX_CTL,
              baud_pkg::OFS_DIV_LO, baud_pkg::OFS_DIV_HI,
              baud_pkg::OFS_TX_CTL};
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++) rchk("reset", ofs[i], 8'h00);
      for (int i = 1; i < 5; i++) begin
         xfer(1'b1, ofs[i], 8'ha5 ^ 8'(i));
         rchk("rw byte", ofs[i], 8'ha5 ^ 8'(i));
      end
      chk("rx byte", {24'h0, rx_byte}, 32'ha4);
      chk("tx byte", {24'h0, tx_byte}, 32'ha1);
      $display("test done: register access");
      xfer(1'b1, baud_pkg::OFS_BAUD_CTL, 8'hff);
      rchk("baud ctl", baud_pkg::OFS_BAUD_CTL, 8'h9b);
      chk("controls", {29'h0, pol, wake, autobaud_enable}, 32'h7);
      idle_lvl <= 1'b1;
      xfer(1'b1, baud_pkg::OFS_BAUD_CTL, 8'h00);
      rchk("idle", baud_pkg::OFS_BAUD_CTL, 8'h40);
      ovf_pulse <= 1'b1;
      @(posedge mclk);
      ovf_pulse <= 1'b0;
      rchk("overflow", baud_pkg::OFS_BAUD_CTL, 8'hc0);
      ovf_pulse <= 1'b1;
      xfer(1'b1, baud_pkg::OFS_BAUD_CTL, 8'h00);
      ovf_pulse <= 1'b0;
      rchk("set beats clear", baud_pkg::OFS_BAUD_CTL, 8'hc0);
      $display("test done: baud control");
      for (int m = 0; m < 8; m++) begin
         xfer(1'b1, baud_pkg::OFS_TX_CTL, {3'h0, m[2], 1'b0, m[0], 2'h0});
         xfer(1'b1, baud_pkg::OFS_BAUD_CTL, {4'h0, m[1], 3'h0});
         @(posedge mclk);
         #1;
         if (m[2])
            pchk("sync", baud_pkg::PRE_DIV4);
         else if (m[1] && m[0])
            pchk("wide high", baud_pkg::PRE_DIV4);
         else if (m[1])
            pchk("wide low", baud_pkg::PRE_DIV16);
         else if (m[0])
            pchk("narrow high", baud_pkg::PRE_DIV16);
         else
            pchk("narrow low", baud_pkg::PRE_DIV64);
      end
      $display("test done: rate modes");
      xfer(1'b1, baud_pkg::OFS_TX_CTL, 8'h00);
      xfer(1'b1, baud_pkg::OFS_BAUD_CTL, 8'h00);
      xfer(1'b1, baud_pkg::OFS_DIV_LO, 8'h02);
      @(posedge mclk);
      #1 chk("tick after write", {31'h0, tick}, 32'h1);
      @(posedge mclk);
      #1 chk("tick gap", {31'h0, tick}, 32'h0);
      repeat (20) @(posedge mclk);
      chk("period narrow", {16'h0, period}, 32'd3);
      xfer(1'b1, baud_pkg::OFS_DIV_HI, 8'h01);
      repeat (20) @(posedge mclk);
      chk("period high ignored", {16'h0, period}, 32'd3);
      xfer(1'b1, baud_pkg::OFS_BAUD_CTL, 8'h08);
      repeat (600) @(posedge mclk);
      chk("period wide", {16'h0, period}, 32'd259);
      $display("test done: divider");
      xfer(1'b0, 12'h014, 8'h00);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      $display("test done: unmapped access");
      report_and_stop();
   end
endmodule // serial_baud_rate_generator_bench

`default_nettype wire
